// >>> hbs_pkg.sv
/*
 * shared constants, states and carrier types of the hibernation and boot sequencer.
 * assumes a single 250 MHz system clock and a synchronous active-high reset.
 */
`default_nettype none
package hbs_pkg;
    // ==========================================================
    // clocks
    localparam int unsigned SYS_CLK_MHZ   = 250;
    localparam int unsigned SLOW_CLK_KHZ  = 32;
    // ==========================================================
    // fuse array
    localparam int unsigned FUSE_BITS     = 6144;
    localparam int unsigned FUSE_BYTES    = FUSE_BITS / 8;
    localparam int unsigned FUSE_ADDR_W   = 10;
    localparam logic [FUSE_ADDR_W-1:0] FUSE_OFS_TRIM = 10'h000;
    localparam logic [FUSE_ADDR_W-1:0] FUSE_OFS_PKG  = 10'h001;
    localparam logic [FUSE_ADDR_W-1:0] FUSE_OFS_MEM  = 10'h002;
    localparam logic [FUSE_ADDR_W-1:0] FUSE_LAST     = 10'h2FF;
    localparam logic [7:0]             FUSE_BLANK    = 8'h00;
    // ==========================================================
    // deep-sleep timer
    localparam int unsigned WAKE_W = 24;
    localparam logic [WAKE_W-1:0] WAKE_ZERO = 24'h000000;
    localparam logic [WAKE_W-1:0] WAKE_ONE  = 24'h000001;
    // ==========================================================
    // pin synchroniser lanes
    localparam int unsigned SYN_W       = 5;
    localparam int unsigned SYN_SLOW    = 0;
    localparam int unsigned SYN_MAIN_EN = 1;
    localparam int unsigned SYN_SLP_EN  = 2;
    localparam int unsigned SYN_CORE_OK = 3;
    localparam int unsigned SYN_IO_OK   = 4;
    // ==========================================================
    // boot sequence
    typedef enum logic [2:0] {
        HBS_ST_OFF      = 3'h0,
        HBS_ST_WAIT_REG = 3'h1,
        HBS_ST_FUSE     = 3'h2,
        HBS_ST_CORES    = 3'h3,
        HBS_ST_CRYSTAL_OSCILLATOR     = 3'h4,
        HBS_ST_RUN      = 3'h5
    } hbs_boot_state_t;

    typedef struct packed {
        logic application_core_power;
        logic wireless_core_power;
        logic crystal_oscillator_power;
        logic application_core_run;
        logic wireless_core_run;
    } hbs_power_t;

    typedef struct packed {
        logic [7:0] trim;
        logic [7:0] package_sel;
        logic [7:0] memory_size;
    } hbs_fuse_cfg_t;

    localparam hbs_power_t    POWER_OFF = 5'h00;
    localparam hbs_fuse_cfg_t CFG_CLEAR = 24'h000000;
endpackage
`default_nettype wire

// >>> hbs_sequencer.sv
/*
 * deep-sleep timer, power-on boot sequencer and one-time fuse array in one module.
 * assumes pins (slow clock, regulator enables, regulator stable flags) are asynchronous
 * and that software-side strobes are synchronous to clk.
 */
// Behaviour
// - on hibernation request, regulator enable out goes low for exactly wake-count slow cycles
// - when the wake-count timer expires, regulator enable out goes high again
// - deep-sleep state and fuse contents survive hibernation; boot state is lost when power drops
// - boot starts on either regulator enable, then waits for core and io regulators stable
// - after regulators are stable, fuse bits load trim, package and memory size settings
// - in the same cycle as the fuse load both cores power up, then crystal oscillator, then both processors released
// - fuse array holds 6144 bits, readable by software after every reset
// - blank fuses read 0; a bit programmed to 1 never returns to 0
// - programming may take several cycles; only bits at 0 change each cycle
`timescale 1ns/1ps
`default_nettype none
module hbs_sequencer (
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            slow_clk_in,
    input  wire logic                            main_regulator_enable_in,
    input  wire logic                            sleep_regulator_enable_in,
    input  wire logic                            core_regulator_stable,
    input  wire logic                            io_regulator_stable,
    input  wire logic                            wake_count_load,
    input  wire logic [hbs_pkg::WAKE_W-1:0]      wake_count_in,
    input  wire logic                            hibernate_req,
    output logic                                 sleep_regulator_enable_out,
    output logic                                 hibernating,
    input  wire logic                            fuse_rd_en,
    input  wire logic                            fuse_pgm_en,
    input  wire logic [hbs_pkg::FUSE_ADDR_W-1:0] fuse_addr,
    input  wire logic [7:0]                      fuse_pgm_data,
    output logic [7:0]                           fuse_rd_data,
    output logic                                 fuse_rd_valid,
    output hbs_pkg::hbs_fuse_cfg_t               fuse_cfg,
    output hbs_pkg::hbs_power_t                  power_ctrl,
    output hbs_pkg::hbs_boot_state_t             boot_state
);
    import hbs_pkg::*;

    function automatic logic fuse_addr_ok(input logic [FUSE_ADDR_W-1:0] a);
        fuse_addr_ok = (a <= FUSE_LAST);
    endfunction

    // ==========================================================
    // pin synchronisers
    logic [SYN_W-1:0] syn1_reg;
    logic [SYN_W-1:0] syn2_reg;
    logic             slow_d_reg;
    logic             slow_edge;
    logic             power_req;
    logic             regs_stable;

    always_ff @(posedge clk) begin
        if (rst) begin
            syn1_reg   <= 5'h00;
            syn2_reg   <= 5'h00;
            slow_d_reg <= 1'b0;
        end else begin
            syn1_reg   <= {io_regulator_stable, core_regulator_stable, sleep_regulator_enable_in,
                           main_regulator_enable_in, slow_clk_in};
            syn2_reg   <= syn1_reg;
            slow_d_reg <= syn2_reg[SYN_SLOW];
        end
    end

    // edge taken after the second stage, so the first stage feeds nothing else
    assign slow_edge   = syn2_reg[SYN_SLOW] & ~slow_d_reg;
    assign power_req   = syn2_reg[SYN_MAIN_EN] | syn2_reg[SYN_SLP_EN];
    assign regs_stable = syn2_reg[SYN_CORE_OK] & syn2_reg[SYN_IO_OK];

    // ==========================================================
    // deep-sleep timer
    logic [WAKE_W-1:0] wake_count_reg;
    logic [WAKE_W-1:0] count_reg;
    logic              sleeping_reg;
    logic              req_d_reg;
    logic              out_reg;
    logic              req_rise;
    logic              enter_sleep;

    assign req_rise    = hibernate_req & ~req_d_reg;
    // a zero count would mean no sleep at all, so it is ignored
    assign enter_sleep = req_rise & ~sleeping_reg & (wake_count_reg != WAKE_ZERO);

    always_ff @(posedge clk) begin
        if (rst) begin
            wake_count_reg <= WAKE_ZERO;
            req_d_reg      <= 1'b0;
        end else begin
            req_d_reg <= hibernate_req;
            if (wake_count_load) begin
                wake_count_reg <= wake_count_in;
            end
        end
    end

    // this state lives in the always-on domain; nothing in boot resets it
    always_ff @(posedge clk) begin
        if (rst) begin
            sleeping_reg <= 1'b0;
            count_reg    <= WAKE_ZERO;
            out_reg      <= 1'b1;
        end else if (enter_sleep) begin
            sleeping_reg <= 1'b1;
            count_reg    <= wake_count_reg;
            out_reg      <= 1'b0;
        end else if (sleeping_reg && slow_edge) begin
            if (count_reg == WAKE_ONE) begin
                sleeping_reg <= 1'b0;
                count_reg    <= WAKE_ZERO;
                out_reg      <= 1'b1;
            end else begin
                count_reg <= count_reg - WAKE_ONE;
            end
        end
    end

    assign sleep_regulator_enable_out = out_reg;
    assign hibernating                = sleeping_reg;

    // ==========================================================
    // fuse array
    // blank fuses model an unprogrammed part; reset must not touch them
    logic [7:0] fuse_mem [0:FUSE_BYTES-1] = '{default: FUSE_BLANK};
    logic [7:0] rd_data_reg;
    logic       rd_valid_reg;

    always_ff @(posedge clk) begin
        if (fuse_pgm_en && fuse_addr_ok(fuse_addr)) begin
            fuse_mem[fuse_addr] <= fuse_mem[fuse_addr] | fuse_pgm_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_reg  <= FUSE_BLANK;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= fuse_rd_en;
            if (fuse_rd_en) begin
                rd_data_reg <= fuse_addr_ok(fuse_addr) ? fuse_mem[fuse_addr] : FUSE_BLANK;
            end
        end
    end

    assign fuse_rd_data  = rd_data_reg;
    assign fuse_rd_valid = rd_valid_reg;

    // ==========================================================
    // boot sequencer
    hbs_boot_state_t state_reg;
    hbs_power_t      power_reg;
    hbs_fuse_cfg_t   cfg_reg;

    always_ff @(posedge clk) begin
        if (rst || !power_req) begin
            state_reg <= HBS_ST_OFF;
            power_reg <= POWER_OFF;
            cfg_reg   <= CFG_CLEAR;
        end else begin
            case (state_reg)
                HBS_ST_OFF: begin
                    state_reg <= HBS_ST_WAIT_REG;
                end
                HBS_ST_WAIT_REG: begin
                    if (regs_stable) begin
                        state_reg <= HBS_ST_FUSE;
                    end
                end
                HBS_ST_FUSE: begin
                    cfg_reg.trim        <= fuse_mem[FUSE_OFS_TRIM];
                    cfg_reg.package_sel <= fuse_mem[FUSE_OFS_PKG];
                    cfg_reg.memory_size <= fuse_mem[FUSE_OFS_MEM];
                    state_reg           <= HBS_ST_CORES;
                    power_reg.application_core_power <= 1'b1;
                    power_reg.wireless_core_power    <= 1'b1;
                end
                HBS_ST_CORES: begin
                    power_reg.crystal_oscillator_power <= 1'b1;
                    state_reg <= HBS_ST_CRYSTAL_OSCILLATOR;
                end
                HBS_ST_CRYSTAL_OSCILLATOR: begin
                    power_reg.application_core_run <= 1'b1;
                    power_reg.wireless_core_run    <= 1'b1;
                    state_reg <= HBS_ST_RUN;
                end
                HBS_ST_RUN: begin
                    state_reg <= HBS_ST_RUN;
                end
                default: begin
                    state_reg <= HBS_ST_OFF;
                    power_reg <= POWER_OFF;
                end
            endcase
        end
    end

    assign power_ctrl = power_reg;
    assign fuse_cfg   = cfg_reg;
    assign boot_state = state_reg;

    // ==========================================================
    // checks
    logic [WAKE_W-1:0]      edges_reg;
    logic [WAKE_W-1:0]      loaded_reg;
    logic                   pgm_chk_reg;
    logic [FUSE_ADDR_W-1:0] pgm_addr_reg;
    logic [7:0]             pgm_expect_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            edges_reg   <= WAKE_ZERO;
            loaded_reg  <= WAKE_ZERO;
            pgm_chk_reg <= 1'b0;
        end else begin
            if (enter_sleep) begin
                edges_reg  <= WAKE_ZERO;
                loaded_reg <= wake_count_reg;
            end else if (sleeping_reg && slow_edge) begin
                edges_reg <= edges_reg + WAKE_ONE;
            end
            pgm_chk_reg <= fuse_pgm_en && fuse_addr_ok(fuse_addr);
        end
        pgm_addr_reg   <= fuse_addr;
        pgm_expect_reg <= fuse_mem[fuse_addr] | fuse_pgm_data;
    end

    AST_SLEEP_LOW: assert property (@(posedge clk) disable iff (rst)
        enter_sleep |=> !sleep_regulator_enable_out && hibernating)
        else $error("regulator enable not dropped on hibernation");

    AST_HOLD_LOW: assert property (@(posedge clk) disable iff (rst)
        hibernating |-> !sleep_regulator_enable_out)
        else $error("regulator enable high while hibernating");

    AST_EXACT_COUNT: assert property (@(posedge clk) disable iff (rst)
        $fell(hibernating) |-> edges_reg == loaded_reg)
        else $error("sleep length differs from wake count");

    AST_WAKE: assert property (@(posedge clk) disable iff (rst)
        hibernating && slow_edge && count_reg == WAKE_ONE && !enter_sleep
        |=> sleep_regulator_enable_out && !hibernating)
        else $error("no wake on timer expiry");

    AST_DECREMENT: assert property (@(posedge clk) disable iff (rst)
        hibernating && slow_edge && count_reg > WAKE_ONE |=> count_reg == $past(count_reg) - WAKE_ONE)
        else $error("wake count not decremented");

    AST_POWER_LOSS: assert property (@(posedge clk) disable iff (rst)
        !power_req |=> boot_state == HBS_ST_OFF && power_ctrl == POWER_OFF)
        else $error("boot state survived loss of power");

    AST_WAIT_STABLE: assert property (@(posedge clk) disable iff (rst)
        boot_state == HBS_ST_WAIT_REG && !regs_stable |=> boot_state != HBS_ST_FUSE)
        else $error("fuse load before regulators stable");

    AST_FUSE_FIRST: assert property (@(posedge clk) disable iff (rst)
        $rose(power_ctrl.application_core_power) |-> $past(state_reg) == HBS_ST_FUSE
        && fuse_cfg.trim == $past(fuse_mem[FUSE_OFS_TRIM]))
        else $error("cores powered without fuse load");

    AST_ORDER: assert property (@(posedge clk) disable iff (rst || !power_req)
        $rose(power_ctrl.application_core_power) |=> power_ctrl.crystal_oscillator_power
        ##1 power_ctrl.application_core_run && power_ctrl.wireless_core_run)
        else $error("power-up order broken");

    AST_FUSE_READ: assert property (@(posedge clk) disable iff (rst)
        fuse_rd_en |=> fuse_rd_valid)
        else $error("fuse read not answered");

    AST_FUSE_MONO: assert property (@(posedge clk) disable iff (rst)
        pgm_chk_reg |-> fuse_mem[pgm_addr_reg] == pgm_expect_reg)
        else $error("fuse bit cleared or wrongly set");

    COV_SLEEP_WAKE: cover property (@(posedge clk) disable iff (rst)
        $fell(hibernating));
    COV_BOOT_RUN: cover property (@(posedge clk) disable iff (rst)
        $rose(power_ctrl.application_core_run));
    COV_FUSE_PGM: cover property (@(posedge clk) disable iff (rst)
        pgm_chk_reg ##1 fuse_rd_valid);
endmodule
`default_nettype wire

// >>> hbs_dummy_end.sv
`default_nettype none
`default_nettype wire

// >>> hbs_far_model.sv
/*
 * far-side model of the sequencer: always-on slow clock and the core and io regulators.
 * assumes the bench clock; power_on is the or of both regulator enables.
 */
`timescale 1ns/1ps
`default_nettype none
module hbs_far_model #(
    parameter int SLOW_HALF  = 20,
    parameter int STABLE_DLY = 10
) (
    input  wire logic clk,
    input  wire logic power_on,
    output logic      slow_clk_in,
    output logic      core_regulator_stable,
    output logic      io_regulator_stable
);
    // ==========================================================
    // slow clock and regulators
    // slow clock runs free but scaled far above 32 kHz so the run stays short
    int   slow_cnt = 0;
    int   on_cnt   = 0;
    logic slow_reg = 1'b0;
    logic core_reg = 1'b0;
    logic io_reg   = 1'b0;
    assign slow_clk_in           = slow_reg;
    assign core_regulator_stable = core_reg;
    assign io_regulator_stable   = io_reg;
    always @(negedge clk) begin
        slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
        if (slow_cnt == SLOW_HALF - 1) begin
            slow_reg <= ~slow_reg;
        end
        on_cnt <= power_on ? on_cnt + 1 : 0;
        // outputs settle some cycles after enable, io later than core
        core_reg <= power_on && (on_cnt >= STABLE_DLY);
        io_reg   <= power_on && (on_cnt >= STABLE_DLY + 3);
    end
endmodule
`default_nettype wire

// >>> tb_top.sv
/*
 * self-checking bench of the hibernation and boot sequencer.
 * assumes hbs_pkg, hbs_sequencer and hbs_far_model compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import hbs_pkg::*;
    // ==========================================================
    // signals
    logic clk = 0, rst = 1, main_sw = 0, sleep_in = 0, wake_load = 0, req = 0, rd_en = 0, pgm_en = 0;
    logic [WAKE_W-1:0]      wake_cnt = '0;
    logic [FUSE_ADDR_W-1:0] addr     = '0;
    logic [7:0]             pdata    = '0;
    logic [7:0]             rd_data;
    logic                   slow, core_ok, io_ok, main_en, out, deep_sleep_unit, rd_valid;
    hbs_fuse_cfg_t          cfg;
    hbs_power_t             pwr;
    hbs_boot_state_t        st;
    int err_total = 0, samples_checked = 0, seed = 12;
    logic [7:0]             shadow [0:FUSE_BYTES-1];
    // main enable is wired to the sleep unit output, as on the board
    assign main_en = main_sw & out;
    initial begin
        for (int i = 0; i < FUSE_BYTES; i++) shadow[i] = FUSE_BLANK;
        forever #2 clk = ~clk;
    end
    hbs_far_model far (.clk(clk), .power_on(main_en | sleep_in), .slow_clk_in(slow),
        .core_regulator_stable(core_ok), .io_regulator_stable(io_ok));
    hbs_sequencer uut (.clk(clk), .rst(rst), .slow_clk_in(slow), .main_regulator_enable_in(main_en),
        .sleep_regulator_enable_in(sleep_in), .core_regulator_stable(core_ok), .io_regulator_stable(io_ok),
        .wake_count_load(wake_load), .wake_count_in(wake_cnt), .hibernate_req(req),
        .sleep_regulator_enable_out(out), .hibernating(deep_sleep_unit), .fuse_rd_en(rd_en), .fuse_pgm_en(pgm_en),
        .fuse_addr(addr), .fuse_pgm_data(pdata), .fuse_rd_data(rd_data), .fuse_rd_valid(rd_valid),
        .fuse_cfg(cfg), .power_ctrl(pwr), .boot_state(st));
    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task automatic stop_test;
        if (err_total == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic logic [7:0] fuse_exp(input logic [FUSE_ADDR_W-1:0] a);
        return (a <= FUSE_LAST) ? shadow[a] : FUSE_BLANK;
    endfunction
    task automatic rd(input logic [FUSE_ADDR_W-1:0] a);
        @(negedge clk);
        rd_en = 1;
        addr  = a;
        @(negedge clk);
        rd_en = 0;
        chk(rd_valid, 1, "read valid");
        chk(rd_data, fuse_exp(a), "fuse data");
    endtask
    task automatic pgm(input logic [FUSE_ADDR_W-1:0] a, input logic [7:0] v);
        @(negedge clk);
        pgm_en = 1;
        addr   = a;
        pdata  = v;
        @(negedge clk);
        pgm_en = 0;
        if (a <= FUSE_LAST) shadow[a] = shadow[a] | v;
    endtask
    task automatic boot_wait;
        int i;
        for (i = 0; i < 300 && st !== HBS_ST_RUN; i++) begin
            @(negedge clk);
            if (st > HBS_ST_WAIT_REG) chk(core_ok & io_ok, 1, "left wait early");
            if (pwr.crystal_oscillator_power === 1'b1)
                chk(pwr.application_core_power & pwr.wireless_core_power, 1, "crystal_oscillator before cores");
            if (pwr.application_core_run === 1'b1)
                chk(pwr.crystal_oscillator_power, 1, "run before crystal_oscillator");
        end
        if (i >= 300) begin
            chk(0, 1, "boot timeout");
            stop_test();
        end else begin
            chk(pwr, 5'h1F, "all powered and running");
            chk(cfg, {fuse_exp(FUSE_OFS_TRIM), fuse_exp(FUSE_OFS_PKG), fuse_exp(FUSE_OFS_MEM)}, "cfg");
        end
    endtask
    task automatic hib_run(input logic [WAKE_W-1:0] n);
        int   i;
        int   cnt;
        logic p;
        p = 1'b1;
        // start just after a slow rising edge so no edge straddles the request
        for (i = 0; i < 100 && !(p === 1'b0 && slow === 1'b1); i++) begin
            p = slow;
            @(negedge clk);
        end
        repeat (5) @(negedge clk);
        wake_load = 1; // count before request
        wake_cnt  = n;
        @(negedge clk);
        wake_load = 0;
        req       = 1;
        repeat (2) @(negedge clk);
        chk(out, 0, "out low on request");
        chk(deep_sleep_unit, 1, "hibernating");
        req = 0;
        cnt = 0;
        p   = slow;
        for (i = 0; i < 2000 && out !== 1'b1; i++) begin
            @(negedge clk);
            if (out === 1'b0 && p === 1'b0 && slow === 1'b1) cnt++;
            p = slow;
            // a repeated request while asleep must be ignored
            if (i == 15) req = 1;
            if (i == 25) begin
                chk(st, HBS_ST_OFF, "boot state lost");
                chk(pwr, POWER_OFF, "power lost");
            end
        end
        chk(cnt, n, "wake count length");
        req = 0;
        chk(out, 1, "out high after expiry");
        boot_wait(); // chip restarts on wake
    endtask
    // ==========================================================
    // scenarios
    initial begin
        repeat (50000) @(posedge clk);
        chk(0, 1, "run timeout");
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 0;
        chk({out, deep_sleep_unit, rd_valid, st}, {3'b100, HBS_ST_OFF}, "reset values");
        chk(pwr, POWER_OFF, "reset power");
        for (int i = 0; i < 8; i++) rd(i == 0 ? FUSE_LAST : 10'({$random(seed)} % 1024));
        for (int i = 0; i < 14; i++) begin
            automatic logic [FUSE_ADDR_W-1:0] a = (i < 3) ? 10'(i) : (i == 3) ? FUSE_LAST :
                (i == 4) ? 10'h300 : 10'({$random(seed)} % 768);
            pgm(a, 8'($random(seed)));
            pgm(a, (i == 5) ? 8'h00 : 8'($random(seed))); // set bits stay set
            rd(a);
        end
        sleep_in = 1; // sleep enable alone starts boot
        boot_wait();
        @(negedge clk);
        sleep_in = 0;
        repeat (4) @(negedge clk);
        chk(st, HBS_ST_OFF, "off on enable drop");
        main_sw = 1;
        boot_wait();
        wake_load = 1;
        wake_cnt  = WAKE_ZERO;
        @(negedge clk);
        wake_load = 0;
        req       = 1;
        repeat (6) @(negedge clk);
        chk(out, 1, "zero count refused");
        req = 0;
        hib_run(WAKE_ONE);
        hib_run(24'({$random(seed)} % 5 + 2));
        stop_test();
    end
endmodule
`default_nettype wire
